/* File: verilog/core_consts.svh */
// Purpose: Shared constants of the 8-bit core datapath
// Assumes: Included by bare name from the modules only, not the package
// Notes: Definitions only, no logic
//
// Summary of operation
// - Every instruction is one fourteen-bit word
// - One full word fetched per instruction cycle
// - Next word fetched while current one executes
// - Non-branching instructions finish in one cycle
// - Program counter addresses internal program memory only
// - Program counter and status live in data space
// - Direct or indirect addressing reaches any register
// - Eight-bit ALU adds, subtracts, shifts, does logic
// - Arithmetic treats operands as two's complement
// - Two operands: accumulator plus register or literal
// - One operand: accumulator or file register
// - Accumulator has no data memory address
// - ALU updates carry, nibble ripple, zero flags
// - Subtraction flags report no-borrow, set when none occurs
// - Four phases; count, latch, then execute
// - Flow change discards prefetched word, two cycles
`ifndef CORE_CONSTS_SVH
`define CORE_CONSTS_SVH

// ****************************************
// Widths and sizes
// ****************************************
`define INSTR_W 14
`define DATA_W 8
`define DADDR_W 7
`define PC_BITS 11
`define PROG_WORDS 2048

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 8
`define DOC_CYCLE_NS 200
`define DOC_CLK_MHZ 20
`define PHASES_PER_CYCLE ((`DOC_CYCLE_NS * `DOC_CLK_MHZ) / 1000)

// ****************************************
// Instruction fields
// ****************************************
`define IR_CLASS 13:12
`define IR_OPC 11:8
`define IR_DEST 7
`define IR_FILE 6:0
`define IR_LIT 7:0
`define IR_JUMP 10:0
`define IR_JSEL 11
`define CLS_BYTE 2'h0
`define CLS_CTRL 2'h2
`define CLS_LIT 2'h3

// ****************************************
// Mapped registers and status bits
// ****************************************
`define ADDR_INDIRECT 7'h00
`define ADDR_PCL 7'h02
`define ADDR_STATUS 7'h03
`define ADDR_FSR 7'h04
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define STATUS_RST 8'h00
`define ZERO_BYTE 8'h00

`endif

/* File: verilog/core_pkg.sv */
// Purpose: Types of the 8-bit core datapath
// Assumes: core_consts.svh available on the include path
// Notes: Types only; numbers live in the header
`default_nettype none
package core_pkg;
    // Instruction cycle phases
    typedef enum logic [1:0] {
        PH_ONE = 2'b00,
        PH_TWO = 2'b01,
        PH_THREE = 2'b10,
        PH_FOUR = 2'b11
    } phase_t;

    // ALU functions
    typedef enum logic [3:0] {
        ALU_NOP = 4'b0000,
        ALU_MOVE = 4'b0001,
        ALU_LOAD = 4'b0010,
        ALU_PASS = 4'b0011,
        ALU_ADD = 4'b0100,
        ALU_SUB = 4'b0101,
        ALU_AND = 4'b0110,
        ALU_IOR = 4'b0111,
        ALU_XOR = 4'b1000,
        ALU_COM = 4'b1001,
        ALU_INC = 4'b1010,
        ALU_DEC = 4'b1011,
        ALU_RLF = 4'b1100,
        ALU_RRF = 4'b1101,
        ALU_SWAP = 4'b1110,
        ALU_CLR = 4'b1111
    } alu_op_t;
endpackage
`default_nettype wire

/* File: verilog/alu_if.sv */
// Purpose: Carrier between the core sequencer and its ALU
// Assumes: core_pkg compiled first
// Notes: Purely combinational signals
`timescale 1ns/100ps
`default_nettype none
interface alu_if;
    import core_pkg::*;
    alu_op_t op;           // Function select
    logic [7:0] a;         // Accumulator operand
    logic [7:0] b;         // File or literal operand
    logic cin;             // Carry in for rotates
    logic [7:0] y;         // Result
    logic c;               // Carry or no-borrow out
    logic dc;              // Nibble carry or no-borrow out
    logic upd_c;           // Function affects carry
    logic upd_dc;          // Function affects nibble flag
    logic upd_z;           // Function affects zero flag
    modport core (output op, a, b, cin, input y, c, dc, upd_c, upd_dc, upd_z);
    modport alu (input op, a, b, cin, output y, c, dc, upd_c, upd_dc, upd_z);
endinterface
`default_nettype wire

/* File: verilog/alu_unit.sv */
// Purpose: Eight-bit two's complement ALU
// Assumes: Operand a is the accumulator, b the file or literal
// Notes: Subtraction computes b minus a
`timescale 1ns/100ps
`default_nettype none
`include "core_consts.svh"
module alu_unit
    import core_pkg::*;
(
    // Operands and results
    alu_if.alu bus
);
    // ****************************************
    // Adder shared by add and subtract
    // ****************************************
    wire is_sub = (bus.op == ALU_SUB);
    // Subtract adds the inverted accumulator plus one
    wire [7:0] addend = is_sub ? ~bus.a : bus.a;
    wire [8:0] sum = {1'b0, bus.b} + {1'b0, addend} + {8'h00, is_sub};
    wire [4:0] nib = {1'b0, bus.b[3:0]} + {1'b0, addend[3:0]} + {4'h0, is_sub};
    // Carry outs read as no-borrow when subtracting
    assign bus.c = (bus.op == ALU_RLF) ? bus.b[7] : (bus.op == ALU_RRF) ? bus.b[0] : sum[8];
    assign bus.dc = nib[4];

    // Flag usage per function
    wire arith = (bus.op == ALU_ADD) || is_sub;
    assign bus.upd_c = arith || (bus.op == ALU_RLF) || (bus.op == ALU_RRF);
    assign bus.upd_dc = arith;
    assign bus.upd_z = !(bus.op inside {ALU_NOP, ALU_MOVE, ALU_LOAD, ALU_RLF, ALU_RRF, ALU_SWAP});

    // ****************************************
    // Result select
    // ****************************************
    always_comb begin
        case (bus.op)
            ALU_MOVE: bus.y = bus.a;
            ALU_LOAD, ALU_PASS: bus.y = bus.b;
            ALU_ADD, ALU_SUB: bus.y = sum[7:0];
            ALU_AND: bus.y = bus.a & bus.b;
            ALU_IOR: bus.y = bus.a | bus.b;
            ALU_XOR: bus.y = bus.a ^ bus.b;
            ALU_COM: bus.y = ~bus.b;
            ALU_INC: bus.y = bus.b + 8'h01;
            ALU_DEC: bus.y = bus.b - 8'h01;
            // Rotates pass through carry
            ALU_RLF: bus.y = {bus.b[6:0], bus.cin};
            ALU_RRF: bus.y = {bus.cin, bus.b[7:1]};
            ALU_SWAP: bus.y = {bus.b[3:0], bus.b[7:4]};
            default: bus.y = `ZERO_BYTE;
        endcase
    end
endmodule
`default_nettype wire

/* File: verilog/core_datapath.sv */
// Purpose: Fetch/execute sequencer and register state of the core
// Assumes: Program and data memories answer within one phase
// Notes: One instruction cycle is four mclk cycles
`timescale 1ns/100ps
`default_nettype none
`include "core_consts.svh"
module core_datapath
    import core_pkg::*;
#(
    parameter int PC_W = `PC_BITS,
    parameter int MEM_WORDS = `PROG_WORDS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Program bus
    output var logic [PC_W-1:0] pc_addr,
    input wire logic [`INSTR_W-1:0] instr_word,
    // Data bus
    output var logic [`DADDR_W-1:0] data_addr,
    input wire logic [`DATA_W-1:0] data_rdata,
    output var logic [`DATA_W-1:0] data_wdata,
    output var logic data_we,
    // Observation
    output var logic [`DATA_W-1:0] status,
    output var logic cycle_clk
);
    // ****************************************
    // State
    // ****************************************
    localparam logic [PC_W-1:0] PC_MASK = PC_W'(MEM_WORDS - 1);
    phase_t phase;                  // Current phase
    logic [PC_W-1:0] pc;            // Next fetch address
    logic [`INSTR_W-1:0] ir;        // Executing word
    logic ir_valid;                 // Executing word is live
    logic [7:0] w;                  // Working accumulator
    logic [7:0] fsr;                // Indirect pointer
    logic [7:0] opnd;               // Captured file operand
    alu_if bus();
    alu_op_t op;

    // ****************************************
    // Decode
    // ****************************************
    // Whole instruction held in a single word
    wire is_byte = (ir[`IR_CLASS] == `CLS_BYTE);
    wire is_lit = (ir[`IR_CLASS] == `CLS_LIT);
    wire is_goto = (ir[`IR_CLASS] == `CLS_CTRL) && ir[`IR_JSEL];
    wire [3:0] opc = ir[`IR_OPC];
    wire [6:0] fld = ir[`IR_FILE];
    wire is_skip = is_byte && (opc == 4'hb || opc == 4'hf);

    function automatic alu_op_t decode_op(input logic byte_f, input logic lit_f, input logic [3:0] o,
                                          input logic d);
        alu_op_t r;
        r = ALU_NOP;
        if (byte_f) begin
            case (o)
                4'h0: r = d ? ALU_MOVE : ALU_NOP;
                4'h1: r = ALU_CLR;
                4'h2: r = ALU_SUB;
                4'h3, 4'hb: r = ALU_DEC;
                4'h4: r = ALU_IOR;
                4'h5: r = ALU_AND;
                4'h6: r = ALU_XOR;
                4'h7: r = ALU_ADD;
                4'h8: r = ALU_PASS;
                4'h9: r = ALU_COM;
                4'ha, 4'hf: r = ALU_INC;
                4'hc: r = ALU_RRF;
                4'hd: r = ALU_RLF;
                4'he: r = ALU_SWAP;
                default: r = ALU_NOP;
            endcase
        end else if (lit_f) begin
            case (o)
                4'h0, 4'h1, 4'h2, 4'h3: r = ALU_LOAD;
                4'h8: r = ALU_IOR;
                4'h9: r = ALU_AND;
                4'ha: r = ALU_XOR;
                4'hc, 4'hd: r = ALU_SUB;
                4'he, 4'hf: r = ALU_ADD;
                default: r = ALU_NOP;
            endcase
        end
        return r;
    endfunction

    assign op = decode_op(is_byte, is_lit, opc, ir[`IR_DEST]);
    // Indirect access goes through the pointer
    wire [6:0] eff_addr = (fld == `ADDR_INDIRECT) ? fsr[6:0] : fld;
    wire wr_f = is_byte && ir[`IR_DEST] && (op != ALU_NOP);
    wire wr_w = (op != ALU_NOP) && !wr_f;
    wire commit = (phase == PH_FOUR) && ir_valid;

    // Mapped registers answer from inside the core
    wire hit_pcl = (data_addr == `ADDR_PCL);
    wire hit_status = (data_addr == `ADDR_STATUS);
    wire hit_fsr = (data_addr == `ADDR_FSR);
    wire hit_int = hit_pcl || hit_status || hit_fsr || (data_addr == `ADDR_INDIRECT);
    wire [7:0] rd_mux = hit_pcl ? pc[7:0] : hit_status ? status : hit_fsr ? fsr :
                        (data_addr == `ADDR_INDIRECT) ? `ZERO_BYTE : data_rdata;

    // ****************************************
    // ALU hookup
    // ****************************************
    // Accumulator plus file or literal
    assign bus.op = op;
    assign bus.a = w;
    assign bus.b = is_lit ? ir[`IR_LIT] : opnd;
    assign bus.cin = status[`ST_C];
    alu_unit u_alu (
        .bus(bus)
    );

    // Skip counters leave the zero flag alone
    wire upd_z = bus.upd_z && !is_skip;
    wire res_zero = (bus.y == `ZERO_BYTE);
    wire pcl_wr = wr_f && hit_pcl;
    // Jump destination as a fetch address, for the branch check
    wire [PC_W-1:0] goto_dest = PC_W'(ir[`IR_JUMP]) & PC_MASK;
    // Any change of flow discards the prefetched word
    wire flush = commit && (is_goto || pcl_wr || (is_skip && res_zero));

    logic [7:0] next_status;
    always_comb begin
        next_status = status;
        if (wr_f && hit_status) begin
            next_status = bus.y;
        end
        // Flags win over a direct write
        if (bus.upd_c) begin
            next_status[`ST_C] = bus.c;
        end
        if (bus.upd_dc) begin
            next_status[`ST_DC] = bus.dc;
        end
        if (upd_z) begin
            next_status[`ST_Z] = res_zero;
        end
    end

    logic [PC_W-1:0] next_pc;
    always_comb begin
        next_pc = pc;
        // Counter advances in phase one, wrapping within memory
        if (phase == PH_ONE) begin
            next_pc = (pc + PC_W'(1)) & PC_MASK;
        end else if (flush && is_goto) begin
            next_pc = PC_W'(ir[`IR_JUMP]) & PC_MASK;
        end else if (flush && pcl_wr) begin
            next_pc = {pc[PC_W-1:8], bus.y} & PC_MASK;
        end
    end

    // ****************************************
    // Phase sequencer
    // ****************************************
    // Four non-overlapping phases per instruction cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= PH_ONE;
            cycle_clk <= 1'b0;
        end else begin
            phase <= phase_t'(phase + 2'b01);
            cycle_clk <= (phase == PH_ONE) || (phase == PH_FOUR);
        end
    end

    // ****************************************
    // Fetch side
    // ****************************************
    // Fetch overlaps execution; word latched in phase four
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pc <= '0;
            pc_addr <= '0;
            ir <= '0;
            ir_valid <= 1'b0;
        end else begin
            pc <= next_pc;
            if (phase == PH_ONE) begin
                pc_addr <= pc;
            end
            if (phase == PH_FOUR) begin
                ir <= instr_word;
                ir_valid <= !flush;
            end
        end
    end

    // ****************************************
    // Execute side
    // ****************************************
    // Address in phase one, operand in phase three, commit in phase four
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            data_addr <= '0;
            opnd <= '0;
            data_we <= 1'b0;
            data_wdata <= '0;
        end else begin
            if (phase == PH_ONE) begin
                data_addr <= eff_addr;
            end
            if (phase == PH_THREE) begin
                opnd <= rd_mux;
            end
            data_we <= commit && wr_f && !hit_int;
            if (commit) begin
                data_wdata <= bus.y;
            end
        end
    end

    // Accumulator stays private to the core
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            w <= `ZERO_BYTE;
            fsr <= `ZERO_BYTE;
            status <= `STATUS_RST;
        end else if (commit) begin
            w <= wr_w ? bus.y : w;
            fsr <= (wr_f && hit_fsr) ? bus.y : fsr;
            status <= next_status;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    a_phase_walk: assert property (phase == PH_ONE |=> phase == PH_TWO ##1 phase == PH_THREE
        ##1 phase == PH_FOUR ##1 phase == PH_ONE) else $error("phase order broken");
    a_fetch_latch: assert property (phase == PH_FOUR |=> ir == $past(instr_word))
        else $error("fetched word not latched");
    a_prefetch_addr: assert property (phase == PH_ONE |=> pc_addr == $past(pc) && pc != $past(pc))
        else $error("fetch address not advanced");
    a_pc_range: assert property (pc_addr <= PC_MASK && pc <= PC_MASK)
        else $error("program counter outside memory");
    a_goto_flush: assert property (commit && is_goto |=> !ir_valid [*4] ##1 pc == (($past(goto_dest, 5) + PC_W'(1)) & PC_MASK))
        else $error("branch did not discard prefetch");
    a_pcl_write: assert property (commit && pcl_wr |=> pc[7:0] == $past(bus.y) && !ir_valid)
        else $error("mapped counter write lost");
    a_indirect_addr: assert property (phase == PH_ONE && fld == `ADDR_INDIRECT |=> {1'b0, data_addr} == ($past(fsr) & 8'h7f))
        else $error("indirect address wrong");
    a_sub_borrow: assert property (commit && op == ALU_SUB |=> status[`ST_C] == ($past(bus.b) >= $past(w)))
        else $error("borrow flag wrong");
    a_zero_flag: assert property (commit && upd_z |=> status[`ST_Z] == ($past(bus.y) == `ZERO_BYTE))
        else $error("zero flag wrong");
    a_acc_load: assert property (commit && wr_w |=> w == $past(bus.y) && !data_we)
        else $error("accumulator not loaded");
    a_single_cycle: assert property (commit && !flush |-> ##4 commit)
        else $error("non-branch cycle stalled");

    c_goto: cover property (commit && is_goto);
    c_sub: cover property (commit && op == ALU_SUB && is_lit);
    c_ind_write: cover property (commit && wr_f && fld == `ADDR_INDIRECT && !hit_int);
    c_skip: cover property (commit && is_skip && res_zero);
endmodule
`default_nettype wire

/* File: tb/prog_data_mem.sv */
// Purpose: Program memory and data file facing the core
// Assumes: Bench preloads prog and ram by hierarchy
// Notes: Slow mode shows inverted values until just in time
`timescale 1ns/100ps
`default_nettype none
`include "core_consts.svh"
module prog_data_mem #(
    parameter int PC_W = `PC_BITS
) (
    // Clock and answer speed
    input wire logic mclk,
    input wire logic slow,
    // Program bus
    input wire logic [PC_W-1:0] pc_addr,
    output logic [`INSTR_W-1:0] instr_word,
    // Data bus
    input wire logic [`DADDR_W-1:0] data_addr,
    output logic [`DATA_W-1:0] data_rdata,
    input wire logic [`DATA_W-1:0] data_wdata,
    input wire logic data_we
);
    // ****************************************
    // Storage
    // ****************************************
    logic [`INSTR_W-1:0] prog [0:(1<<PC_W)-1]; // One whole word per instruction
    logic [`DATA_W-1:0] ram [0:127]; // Data file, separate from program
    logic [PC_W-1:0] last_pc = '0; // Fetch address one edge ago
    logic [`DADDR_W-1:0] last_da = '0; // Data address one edge ago
    logic pc_old = 1'b0; // Fetch address steady for two edges
    // Stale values are inverted, never held, so early sampling shows
    assign instr_word = (!slow || (pc_old && pc_addr == last_pc)) ? prog[pc_addr] : ~prog[pc_addr];
    assign data_rdata = (!slow || data_addr == last_da) ? ram[data_addr] : ~ram[data_addr];
    // Age addresses; the write lands with the address still present
    always @(posedge mclk) begin
        pc_old <= (pc_addr == last_pc);
        last_pc <= pc_addr;
        last_da <= data_addr;
        if (data_we) begin
            ram[data_addr] <= data_wdata;
        end
    end
endmodule
`default_nettype wire

/* File: tb/harvard_core_alu_datapath_bench.sv */
// Purpose: Random programs run on the core against a model
// Assumes: Mid-range style encoding, flags as in the hand-over
// Notes: Every external write is compared, with flags and timing
`timescale 1ns/100ps
`default_nettype none
`include "core_consts.svh"
module harvard_core_alu_datapath_bench;
    import core_pkg::*;
    // ****************************************
    // Signals and scoreboard
    // ****************************************
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic slow = 1'b0; // Memory answers late when set
    logic [`PC_BITS-1:0] pc_addr;
    logic [`INSTR_W-1:0] instr_word;
    logic [`DADDR_W-1:0] data_addr;
    logic [`DATA_W-1:0] data_rdata;
    logic [`DATA_W-1:0] data_wdata;
    logic [`DATA_W-1:0] status;
    logic data_we;
    logic cycle_clk;
    int errors = 0;
    int checks_done = 0;
    int mcnt = 0; // Edges since start
    int off = -1; // Edge of model cycle zero, set by first write
    int qa[$], qd[$], qs[$], qt[$]; // Expected address, data, flags, cycle
    int img[$]; // Program image
    int mr [0:127]; // Model data file
    int lmap [0:15] = '{8, 8, 8, 8, 0, 0, 0, 0, 4, 5, 6, 0, 2, 2, 7, 7}; // Literal to byte op
    int lsel [0:5] = '{0, 8, 9, 10, 12, 14}; // Literal kinds generated
    // Clock of 8 ns
    initial begin
        forever #4 mclk = ~mclk;
    end
    core_datapath dut (.mclk(mclk), .arst_n(arst_n), .pc_addr(pc_addr), .instr_word(instr_word),
        .data_addr(data_addr), .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we),
        .status(status), .cycle_clk(cycle_clk));
    prog_data_mem mem (.mclk(mclk), .slow(slow), .pc_addr(pc_addr), .instr_word(instr_word),
        .data_addr(data_addr), .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic mismatch(input string msg);
        errors++;
        $display("MISMATCH at %0t: %s", $time, msg);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Random program: pointer setup, ops with jumps, status read, spin
    task automatic build(input int n);
        int op;
        int f;
        // Pointer setup, then a counter write that hops over one word
        img = {'h3025, 'h0084, 'h3005, 'h0082, 'h0000};
        for (int i = 0; i < n; i++) begin
            f = ($urandom % 9 == 0) ? 0 : 32 + $urandom % 8; // File 0 goes through the pointer
            op = $urandom % 16;
            if (i % 5 == 4) begin
                img.push_back('h2800 | (img.size() + 2)); // Jump over the next word
            end else if ($urandom % 4 == 0) begin
                img.push_back('h3000 | (lsel[$urandom % 6] << 8) | ($urandom % 256));
            end else begin
                img.push_back((op << 8) | ((op == 0 ? 1 : $urandom % 2) << 7) | f);
            end
        end
        img.push_back('h0803);
        img.push_back('h00af);
        img.push_back('h2800 | img.size());
    endtask
    // Reference interpreter, counting instruction cycles
    task automatic run_model();
        int pc, t, w, c, dc, z, fsr, sk, ins, op, ea, v, r, lit;
        pc = 0;
        t = 0;
        w = 0;
        c = 0;
        dc = 0;
        z = 0;
        fsr = 0;
        sk = 0;
        while (pc < img.size() - 1) begin
            ins = img[pc];
            pc++;
            t++;
            if (sk) begin
                sk = 0; // Flushed word still costs a cycle
            end else if (ins[13:12] == 2) begin
                pc = ins & 'h7ff;
                t++; // Prefetched word discarded
            end else begin
                lit = (ins[13:12] == 3);
                op = lit ? lmap[ins[11:8]] : ins[11:8];
                ea = (ins[6:0] == 0) ? fsr : ins[6:0];
                v = lit ? ins[7:0] : (ea == 3 ? (z << 2) | (dc << 1) | c : mr[ea]);
                case (op)
                    0: r = w;
                    1: r = 0;
                    2: begin
                        r = (v - w) & 255;
                        c = v >= w;
                        dc = (v & 15) >= (w & 15);
                    end
                    3, 11: r = (v - 1) & 255;
                    4: r = v | w;
                    5: r = v & w;
                    6: r = v ^ w;
                    7: begin
                        r = (v + w) & 255;
                        c = (v + w) > 255;
                        dc = (v & 15) + (w & 15) > 15;
                    end
                    8: r = v;
                    9: r = ~v & 255;
                    10, 15: r = (v + 1) & 255;
                    12: begin
                        r = (v >> 1) | (c << 7);
                        c = v & 1;
                    end
                    13: begin
                        r = ((v << 1) | c) & 255;
                        c = v >> 7;
                    end
                    default: r = ((v << 4) | (v >> 4)) & 255;
                endcase
                sk = (op == 11 || op == 15) && r == 0;
                if (op >= 1 && op <= 10 && !(lit && op == 8)) begin
                    z = (r == 0);
                end
                if (lit || !ins[7]) begin
                    w = r;
                end else if (ea == 4) begin
                    fsr = r; // Pointer is inside the core, no bus write
                end else if (ea == 2) begin
                    pc = (pc & 'h700) | r; // Counter low byte write is a jump
                    t++; // Prefetched word discarded
                end else begin
                    mr[ea] = r;
                    qa.push_back(ea);
                    qd.push_back(r);
                    qs.push_back((z << 2) | (dc << 1) | c);
                    qt.push_back(t);
                end
            end
        end
    endtask
    // ****************************************
    // Write monitor
    // ****************************************
    always @(posedge mclk) begin
        mcnt <= mcnt + 1;
        if (arst_n === 1'b1 && data_we === 1'b1) begin
            checks_done++;
            if (qa.size() == 0) begin
                mismatch("write with none expected");
            end else begin
                if (off < 0) begin
                    off = mcnt - 4 * qt[0];
                end
                if (data_addr !== qa[0][6:0] || data_wdata !== qd[0][7:0]) begin
                    mismatch("write address or data");
                end
                if (status[2:0] !== qs[0][2:0]) begin
                    mismatch("status flags");
                end
                if (mcnt != off + 4 * qt[0]) begin
                    mismatch("write in wrong instruction cycle");
                end
                void'(qa.pop_front());
                void'(qd.pop_front());
                void'(qs.pop_front());
                void'(qt.pop_front());
            end
        end
        // Instruction rate clock is high in phases one and two
        if (arst_n === 1'b1 && off >= 0) begin
            checks_done++;
            if (cycle_clk !== (((mcnt - off) % 4) < 2)) begin
                mismatch("instruction rate clock out of step");
            end
        end
    end
    // ****************************************
    // Main sequence: fast memory, then slow memory after a mid-run reset
    // ****************************************
    initial begin
        int k;
        void'($urandom(57));
        for (int pass = 0; pass < 2; pass++) begin
            @(posedge mclk);
            arst_n <= 1'b0;
            slow <= pass[0];
            build(40);
            for (int i = 0; i < 2048; i++) begin
                mem.prog[i] = (i < img.size()) ? img[i] : 0;
            end
            for (int i = 0; i < 128; i++) begin
                mr[i] = $urandom % 256;
                mem.ram[i] = mr[i];
            end
            repeat (3) @(posedge mclk);
            checks_done++;
            if (status !== 8'h00 || data_we !== 1'b0) begin
                mismatch("outputs not cleared in reset");
            end
            off = -1;
            run_model();
            arst_n <= 1'b1;
            for (k = 0; k < 2000 && qa.size() > 0; k++) begin
                @(posedge mclk);
            end
            if (qa.size() > 0) begin
                mismatch("expected writes never came");
                give_verdict();
            end
            repeat (20) @(posedge mclk);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
